// >>> rtl/pfl_params.svh
/*
 Constants of the parallel flash page loader: select codes, commands and timing counts.
 Assumes it is included by bare name from the package and the checker.
*/
// Summary of operation
// - select pattern 10 makes the next load strobe capture a command byte from the data bus.
// - command byte 0001 0000 with byte select low is Write Flash and opens a page-load session.
// - a rising edge on the load strobe pin captures the data bus into the target chosen by the selects.
// - select pattern 00 makes the load strobe capture an address byte.
// - during address loading byte select low steers the byte into the low half of the address.
// - select 01 with byte select low captures the data bus as the low data byte.
// - select 01 with byte select high captures the data bus as the high data byte.
// - a rising page-latch pulse with byte select high writes both data bytes into the page buffer.
// - low address bits pick the word in the page buffer, high bits pick the flash page.
// - with pages under 256 words the surplus top bits of the address low byte are page bits.
// - program data is gathered in a page buffer so one full page is programmed at once.
// - a negative write-strobe pulse starts the loaded command and ready_busy_out is low until done.
// - command byte 1000 0000 with byte select low is Chip Erase; the code takes it as Chip Erase at either byte select level.
`ifndef PFL_PARAMS_SVH
`define PFL_PARAMS_SVH
`define PFL_SEL_ADDR      2'h0
`define PFL_SEL_DATA      2'h1
`define PFL_SEL_CMD       2'h2
`define PFL_CMD_WRFLASH   8'h10
`define PFL_CMD_ERASE     8'h80
`define PFL_ADDR_RST      16'h0000
`define PFL_CMD_RST       8'h00
`define PFL_WRITE_TIME_US 4500
`define PFL_WRITE_CYC     (`PFL_WRITE_TIME_US * 50)
`endif

// >>> rtl/pfl_pkg.sv
/*
 Types of the parallel flash page loader.
 Assumes pfl_params.svh sits on the include path.
*/
package pfl_pkg;
	`include "pfl_params.svh"
	typedef enum logic [2:0] {
		PFL_IDLE  = 3'b001,
		PFL_WRITE = 3'b010,
		PFL_ERASE = 3'b100
	} pfl_state_e;
endpackage

// >>> rtl/pfl_loader.sv
/*
 Page loader: command, address and data capture from programmer pins, page buffer and
 a timed program/erase busy phase with an output port for the flash array.
 Assumes the programmer pins are asynchronous to mclk and that pulses span several cycles.
 Assumes also that the flash array takes the streamed page words as they appear, with no
 answer back; the page buffer itself is not cleared by reset.
*/
`timescale 1ns/1ps
module pfl_loader
	import pfl_pkg::*;
#(
	parameter int PAGE_AW   = 7,
	parameter int BUSY_CYC  = `PFL_WRITE_CYC
) (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                load_select_hi,
	input  wire logic                load_select_lo,
	input  wire logic                byte_select,
	input  wire logic                load_strobe,
	input  wire logic                page_latch_strobe,
	input  wire logic                write_strobe_b,
	input  wire logic [7:0]          data_in,
	output logic                     ready_busy_out,
	output logic                     write_session,
	output logic [7:0]               command_out,
	output logic [15:0]              address_out,
	output logic [7:0]               page_select,
	output logic                     prog_start,
	output logic                     erase_start,
	output logic [15:0]              prog_word,
	output logic [PAGE_AW-1:0]       prog_word_idx
);
	// words per page; the buffer and the streaming counter are sized from it
	localparam int PW = 1 << PAGE_AW;

	// three-stage synchronisers for the strobe pins
	logic [2:0] ls_sync_r, ls_sync_nxt;
	logic [2:0] pl_sync_r, pl_sync_nxt;
	logic [2:0] wr_sync_r, wr_sync_nxt;
	logic       ls_lvl_r, ls_lvl_nxt;
	logic       pl_lvl_r, pl_lvl_nxt;
	logic       wr_lvl_r, wr_lvl_nxt;
	logic       ls_rise, pl_rise, wr_fall;

	// level taken over once stages two and three agree; a pin that bounces
	// for a single cycle never reaches the agreed level
	function automatic logic agreed(input logic [2:0] s, input logic lvl);
		agreed = (s[2] == s[1]) ? s[2] : lvl;
	endfunction

	// one-cycle edge: the agreed level is about to move to want
	function automatic logic moves_to(input logic [2:0] s, input logic lvl, input logic want);
		moves_to = (s[2] == s[1]) && (s[2] == want) && (lvl != want);
	endfunction

	always_comb begin
		ls_sync_nxt = {ls_sync_r[1:0], load_strobe};
		pl_sync_nxt = {pl_sync_r[1:0], page_latch_strobe};
		wr_sync_nxt = {wr_sync_r[1:0], write_strobe_b};
		ls_lvl_nxt  = agreed(ls_sync_r, ls_lvl_r);
		pl_lvl_nxt  = agreed(pl_sync_r, pl_lvl_r);
		wr_lvl_nxt  = agreed(wr_sync_r, wr_lvl_r);
	end

	// reset levels equal the idle pin levels, so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ls_sync_r <= 3'h0;
			pl_sync_r <= 3'h0;
			wr_sync_r <= 3'h7;
			ls_lvl_r  <= 1'h0;
			pl_lvl_r  <= 1'h0;
			wr_lvl_r  <= 1'h1;
		end else begin
			ls_sync_r <= ls_sync_nxt;
			pl_sync_r <= pl_sync_nxt;
			wr_sync_r <= wr_sync_nxt;
			ls_lvl_r  <= ls_lvl_nxt;
			pl_lvl_r  <= pl_lvl_nxt;
			wr_lvl_r  <= wr_lvl_nxt;
		end
	end

	// edges judged on stages two and three only
	assign ls_rise = moves_to(ls_sync_r, ls_lvl_r, 1'b1);
	assign pl_rise = moves_to(pl_sync_r, pl_lvl_r, 1'b1);
	assign wr_fall = moves_to(wr_sync_r, wr_lvl_r, 1'b0);

	// selects and data are held by the programmer around the strobe, so one
	// sampling at the strobe edge is enough; a late select change is not seen
	logic [1:0] sel_r, sel_nxt;
	logic       bs_r, bs_nxt;
	logic [7:0] din_r, din_nxt;

	always_comb begin
		sel_nxt = {load_select_hi, load_select_lo};
		bs_nxt  = byte_select;
		din_nxt = data_in;
	end

	// three stages, like the strobes, so the bus value seen at the agreed
	// strobe edge is at least three cycles old and long settled
	logic [1:0] sel_q_r, sel_qq_r;
	logic       bs_q_r, bs_qq_r;
	logic [7:0] din_q_r, din_qq_r;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sel_r    <= 2'h0;
			bs_r     <= 1'h0;
			din_r    <= 8'h00;
			sel_q_r  <= 2'h0;
			bs_q_r   <= 1'h0;
			din_q_r  <= 8'h00;
			sel_qq_r <= 2'h0;
			bs_qq_r  <= 1'h0;
			din_qq_r <= 8'h00;
		end else begin
			sel_r    <= sel_nxt;
			bs_r     <= bs_nxt;
			din_r    <= din_nxt;
			sel_q_r  <= sel_r;
			bs_q_r   <= bs_r;
			din_q_r  <= din_r;
			sel_qq_r <= sel_q_r;
			bs_qq_r  <= bs_q_r;
			din_qq_r <= din_q_r;
		end
	end

	// capture registers
	logic [7:0]  cmd_r, cmd_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0]  dlo_r, dlo_nxt;
	logic [7:0]  dhi_r, dhi_nxt;
	logic        sess_r, sess_nxt;
	logic        busy_w;

	// one capture per agreed strobe edge; loads during busy are dropped, not queued
	always_comb begin
		cmd_nxt  = cmd_r;
		addr_nxt = addr_r;
		dlo_nxt  = dlo_r;
		dhi_nxt  = dhi_r;
		sess_nxt = sess_r;
		if (ls_rise && !busy_w) begin
			case (sel_qq_r)
				`PFL_SEL_CMD: begin
					// only the write command with byte select low opens a session
					cmd_nxt  = din_qq_r;
					sess_nxt = (!bs_qq_r && din_qq_r == `PFL_CMD_WRFLASH);
				end
				`PFL_SEL_ADDR: begin
					// byte select high loads the address high byte
					if (!bs_qq_r)
						addr_nxt[7:0] = din_qq_r;
					else
						addr_nxt[15:8] = din_qq_r;
				end
				`PFL_SEL_DATA: begin
					if (!bs_qq_r)
						dlo_nxt = din_qq_r;
					else
						dhi_nxt = din_qq_r;
				end
				default: begin
					cmd_nxt = cmd_r; // pattern 11 is not a load target
				end
			endcase
		end
	end

	// capture registers hold until the next load of the same target
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cmd_r  <= `PFL_CMD_RST;
			addr_r <= `PFL_ADDR_RST;
			dlo_r  <= 8'h00;
			dhi_r  <= 8'h00;
			sess_r <= 1'h0;
		end else begin
			cmd_r  <= cmd_nxt;
			addr_r <= addr_nxt;
			dlo_r  <= dlo_nxt;
			dhi_r  <= dhi_nxt;
			sess_r <= sess_nxt;
		end
	end

	// page buffer: word index from low address bits
	logic [15:0]        page_mem [PW];
	logic [PAGE_AW-1:0] word_idx;
	logic               latch_go;

	// a latch is refused without an open session or with byte select low
	assign word_idx = addr_r[PAGE_AW-1:0];
	assign latch_go = pl_rise && bs_qq_r && sess_r && !busy_w;

	// one word per accepted latch; the buffer has no reset, each page refills it
	always_ff @(posedge mclk) begin
		if (latch_go)
			page_mem[word_idx] <= {dhi_r, dlo_r};
	end

	// busy sequencer
	// the counter is wide enough for the full-length timer at mclk
	pfl_state_e      st_r, st_nxt;
	logic [31:0]     cnt_r, cnt_nxt;
	logic [PAGE_AW:0] rd_r, rd_nxt;
	logic            pstart_nxt, estart_nxt;
	logic            pstart_r, estart_r;
	logic [15:0]     pword_r, pword_nxt;
	logic [PAGE_AW-1:0] pidx_r, pidx_nxt;

	// busy is any state but idle; it gates every load and latch
	assign busy_w = (st_r != PFL_IDLE);

	// idle waits for a write-strobe edge; commands other than the two known
	// ones are ignored and leave ready high
	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		rd_nxt     = rd_r;
		pstart_nxt = 1'h0;
		estart_nxt = 1'h0;
		pword_nxt  = pword_r;
		pidx_nxt   = pidx_r;
		case (st_r)
			PFL_IDLE: begin
				cnt_nxt = 32'h0;
				rd_nxt  = '0;
				if (wr_fall) begin
					// a write needs the session opened by the write command
					if (cmd_r == `PFL_CMD_WRFLASH && sess_r) begin
						st_nxt     = PFL_WRITE;
						pstart_nxt = 1'h1;
					end else if (cmd_r == `PFL_CMD_ERASE) begin
						st_nxt     = PFL_ERASE;
						estart_nxt = 1'h1;
					end
				end
			end
			PFL_WRITE: begin
				// the whole page streams out once, word by word
				if (rd_r < (PAGE_AW+1)'(PW)) begin
					pword_nxt = page_mem[rd_r[PAGE_AW-1:0]];
					pidx_nxt  = rd_r[PAGE_AW-1:0];
					rd_nxt    = rd_r + 1'b1;
				end
				// the timer runs on after the last word so the array gets its full time
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r >= 32'(BUSY_CYC - 1))
					st_nxt = PFL_IDLE;
			end
			PFL_ERASE: begin
				// erase reuses the program timer; a slower array would need its own count
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r >= 32'(BUSY_CYC - 1))
					st_nxt = PFL_IDLE;
			end
			default: begin
				st_nxt = PFL_IDLE;
			end
		endcase
	end

	// sequencer registers; start pulses last exactly one cycle
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_r     <= PFL_IDLE;
			cnt_r    <= 32'h0;
			rd_r     <= '0;
			pstart_r <= 1'h0;
			estart_r <= 1'h0;
			pword_r  <= 16'h0000;
			pidx_r   <= '0;
		end else begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			rd_r     <= rd_nxt;
			pstart_r <= pstart_nxt;
			estart_r <= estart_nxt;
			pword_r  <= pword_nxt;
			pidx_r   <= pidx_nxt;
		end
	end

	// page number from address bits above the word index
	always_comb begin
		page_select = addr_r[PAGE_AW +: 8];
	end

	// ports: all but ready come straight from a register, so neither the
	// flash array nor the programmer ever sees a decode glitch
	assign ready_busy_out = ~busy_w;
	assign write_session  = sess_r;
	assign command_out    = cmd_r;
	assign address_out    = addr_r;
	assign prog_start     = pstart_r;
	assign erase_start    = estart_r;
	assign prog_word      = pword_r;
	assign prog_word_idx  = pidx_r;
endmodule // pfl_loader

// >>> bench/pfl_loader_checker.sv
/* output checks of the page loader.
 assumes a bind onto pfl_loader and mclk/rst_b of the one domain. */
`timescale 1ns/1ps
`include "pfl_params.svh"
module pfl_checker
	import pfl_pkg::*;
#(
	parameter int PAGE_AW  = 7,
	parameter int BUSY_CYC = `PFL_WRITE_CYC
) (
	input wire logic               mclk,
	input wire logic               rst_b,
	input wire logic               ready_busy_out,
	input wire logic               write_session,
	input wire logic [7:0]         command_out,
	input wire logic [15:0]        address_out,
	input wire logic [7:0]         page_select,
	input wire logic               prog_start,
	input wire logic               erase_start,
	input wire logic [PAGE_AW-1:0] prog_word_idx
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// busy cycles so far; a counter, since the busy time is far beyond a delay range
	logic [31:0] busy_n;
	always_ff @(posedge mclk) begin
		if (!rst_b || ready_busy_out)
			busy_n <= 32'h0;
		else
			busy_n <= busy_n + 32'h1;
	end
	// busy phase opens
	sequence s_go;
		$fell(ready_busy_out);
	endsequence
	chk_busy_hold: assert property (s_go |-> !ready_busy_out[*8])
		else $error("busy ended too soon");
	chk_busy_end: assert property (busy_n <= 32'(BUSY_CYC))
		else $error("busy never ended");
	chk_busy_len: assert property ($rose(ready_busy_out) |-> busy_n == 32'(BUSY_CYC))
		else $error("busy length wrong");
	chk_prog_cmd: assert property (prog_start |-> write_session && !ready_busy_out && command_out == `PFL_CMD_WRFLASH)
		else $error("write began without write command");
	chk_erase_cmd: assert property (erase_start |-> !prog_start && command_out == `PFL_CMD_ERASE)
		else $error("erase began without erase command");
	chk_start_once: assert property (prog_start || erase_start |=> !prog_start && !erase_start)
		else $error("start pulse too long");
	chk_page_bits: assert property (page_select == address_out[PAGE_AW+7:PAGE_AW])
		else $error("page select not above word index");
	chk_addr_idle: assert property ($changed(address_out) |-> ready_busy_out)
		else $error("address moved while busy");
	chk_idx_walk: assert property (prog_start |=> prog_word_idx == 0 ##1 prog_word_idx == 1)
		else $error("page words not streamed in order");
	chk_session: assert property ($rose(write_session) |-> command_out == `PFL_CMD_WRFLASH)
		else $error("session without write command");
endmodule // pfl_checker
bind pfl_loader pfl_checker #(.PAGE_AW(PAGE_AW), .BUSY_CYC(BUSY_CYC)) pfl_checker_i (.mclk,
	.rst_b, .ready_busy_out,
	.write_session, .command_out, .address_out, .page_select, .prog_start, .erase_start,
	.prog_word_idx);

// >>> bench/pfl_programmer.sv
/* parallel programmer model driving the loader pins.
 assumes the bench calls its tasks; pins change on falling mclk. */
`timescale 1ns/1ps
module pfl_programmer (
	input  wire logic       mclk,
	input  wire logic       ready_busy_out,
	output logic            load_select_hi,
	output logic            load_select_lo,
	output logic            byte_select,
	output logic            load_strobe,
	output logic            page_latch_strobe,
	output logic            write_strobe_b,
	output logic [7:0]      data_in
);
	// idle pins, write strobe inactive high
	initial begin
		{load_select_hi, load_select_lo, byte_select, load_strobe} = 4'h0;
		page_latch_strobe = 1'b0;
		write_strobe_b = 1'b1;
		data_in = 8'h00;
	end
	// selects held around the pulse; pg picks the page latch pin
	task ld(input logic [1:0] sel, input logic bs, input logic [7:0] d, input bit pg);
		@(negedge mclk);
		{load_select_hi, load_select_lo} = sel;
		byte_select = bs;
		data_in = d;
		repeat (4) @(negedge mclk);
		if (pg) page_latch_strobe = 1'b1;
		else load_strobe = 1'b1;
		repeat (5) @(negedge mclk);
		{page_latch_strobe, load_strobe} = 2'h0;
		repeat (5) @(negedge mclk);
		data_in = ~d; // hold over: bus no longer valid
	endtask
	// negative start pulse
	task wr();
		@(negedge mclk);
		write_strobe_b = 1'b0;
		repeat (5) @(negedge mclk);
		write_strobe_b = 1'b1;
		repeat (2) @(negedge mclk);
	endtask
	// no new command until ready, bounded
	task wait_ready(output bit ok);
		ok = 1'b0;
		repeat (1000) begin
			@(negedge mclk);
			if (ready_busy_out === 1'b1) ok = 1'b1;
			if (ok) break;
		end
	endtask
endmodule // pfl_programmer

// >>> bench/parallel_flash_page_loader_tb.sv
/* self-checking bench of the page loader.
 assumes pfl_programmer as the pin driver and a 50 MHz mclk. */
`timescale 1ns/1ps
module parallel_flash_page_loader_tb;
	logic mclk = 1'b0, rst_b = 1'b0, ready_busy_out, write_session, prog_start, erase_start, ok;
	logic lsh, lsl, bsel, lstb, pstb, wstb_b;
	logic [7:0] data_in, command_out, page_select;
	logic [15:0] address_out, prog_word, seen [128], w [2];
	logic [6:0] prog_word_idx;
	int bad_count = 0, n_compared = 0, cyc = 0, st_cnt = 0;
	bit saw_erase = 0;
	pfl_loader #(.PAGE_AW(7), .BUSY_CYC(200)) pfl_loader_i (.mclk, .rst_b, .load_select_hi(lsh),
		.load_select_lo(lsl), .byte_select(bsel), .load_strobe(lstb), .page_latch_strobe(pstb),
		.write_strobe_b(wstb_b), .data_in, .ready_busy_out, .write_session, .command_out,
		.address_out, .page_select, .prog_start, .erase_start, .prog_word, .prog_word_idx);
	pfl_programmer pfl_programmer_i (.mclk, .ready_busy_out, .load_select_hi(lsh),
		.load_select_lo(lsl), .byte_select(bsel), .load_strobe(lstb), .page_latch_strobe(pstb),
		.write_strobe_b(wstb_b), .data_in);
	always #10 mclk = ~mclk;
	// records streamed page words at the falling edge, where they are settled;
	// words follow the start pulse by one cycle; ceiling far above the ~700 cycles needed
	always @(negedge mclk) begin
		cyc++;
		if (erase_start === 1'b1) saw_erase = 1'b1;
		if (st_cnt > 0) begin
			seen[prog_word_idx] = prog_word;
			st_cnt--;
		end
		if (prog_start === 1'b1) st_cnt = 128;
		if (cyc == 6000) begin
			bad_count++;
			give_verdict();
		end
	end
	task cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task give_verdict();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		w[0] = 16'hC33C;
		w[1] = 16'h5AA5;
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		cmp({ready_busy_out, write_session, command_out, address_out}, 32'h2000000);
		pfl_programmer_i.ld(2'h2, 1'b0, 8'h80, 0);
		cmp({write_session, command_out}, 9'h080);
		pfl_programmer_i.ld(2'h3, 1'b0, 8'h55, 0);
		cmp(command_out, 8'h80);
		pfl_programmer_i.ld(2'h2, 1'b0, 8'h10, 0);
		cmp(write_session, 1'b1);
		pfl_programmer_i.ld(2'h0, 1'b1, 8'h01, 0);
		for (int i = 0; i < 2; i++) begin
			pfl_programmer_i.ld(2'h0, 1'b0, i ? 8'h80 : 8'hFF, 0);
			cmp(address_out, i ? 16'h0180 : 16'h01FF);
			pfl_programmer_i.ld(2'h1, 1'b0, w[i][7:0], 0);
			pfl_programmer_i.ld(2'h1, 1'b1, w[i][15:8], 0);
			pfl_programmer_i.ld(2'h0, 1'b1, 8'h00, 1);
		end
		pfl_programmer_i.ld(2'h0, 1'b0, 8'h81, 0);
		pfl_programmer_i.ld(2'h0, 1'b0, 8'h00, 1);
		cmp(page_select, 8'h03);
		pfl_programmer_i.wr();
		cmp(ready_busy_out, 1'b0);
		pfl_programmer_i.ld(2'h2, 1'b0, 8'h80, 0);
		cmp(command_out, 8'h10);
		pfl_programmer_i.wait_ready(ok);
		cmp(ok, 1'b1);
		cmp({seen[127], seen[0]}, {w[0], w[1]});
		cmp(seen[1] === w[1], 1'b0);
		pfl_programmer_i.ld(2'h2, 1'b0, 8'h80, 0);
		pfl_programmer_i.wr();
		pfl_programmer_i.wait_ready(ok);
		cmp({ok, saw_erase, write_session}, 3'h6);
		pfl_programmer_i.ld(2'h2, 1'b0, 8'h42, 0);
		pfl_programmer_i.wr();
		cmp(ready_busy_out, 1'b1);
		give_verdict();
	end
endmodule // parallel_flash_page_loader_tb
